// ===== verilog/cmbm_pkg.sv
// Constants and types for the CAN message buffer manager.
// Assumes an APB master and an external CAN bit engine.
package cmbm_pkg;
   localparam int FRAME_BYTES = 13;
   localparam int TX_N = 3;
   typedef logic [FRAME_BYTES-1:0][7:0] cmbm_frame_t;
   typedef struct packed {
      logic        hit;
      logic        own;
      cmbm_frame_t frame;
   } cmbm_rx_t;
   localparam logic [11:0] A_CTRL   = 12'h000;
   localparam logic [11:0] A_RXFLAG = 12'h004;
   localparam logic [11:0] A_TXFLAG = 12'h008;
   localparam logic [11:0] A_TXCTRL = 12'h00C;
   localparam logic [11:0] A_PORT   = 12'h010;
   localparam logic [11:0] A_DDR    = 12'h014;
   localparam logic [11:0] A_MASK   = 12'h018;
   localparam logic [5:0]  RX_WIN   = 6'h01;
   localparam logic [3:0]  TX_WIN   = 4'h1;
   localparam logic [3:0]  LOCAL_PRIORITY_FIELD_IDX = 4'hD;
   localparam int CTRL_LOOP = 0;
   localparam int CTRL_EN   = 1;
   localparam int RXF_BIT   = 0;
   localparam int OVR_BIT   = 1;
   localparam int ABORT_ACKNOWLEDGE_BIT_LSB = 4;
   localparam int MASK_RXF  = 0;
   localparam int MASK_OVR  = 1;
   localparam int MASK_TXE  = 2;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] DDR_RST  = 8'h00;
   localparam logic [2:0] TXE_RST  = 3'h7;
endpackage : cmbm_pkg

// ===== verilog/cmbm_core.sv
// Receive FIFO, transmit buffers and scheduler with APB registers.
// Assumes a bit engine that frames, filters and arbitrates on the bus.
`timescale 1ns/10ps
`default_nettype none
module cmbm_core (
   input  wire logic               ref_clk,
   input  wire logic               rst,
   input  wire logic [11:0]        paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               bus_receive_input,
   output logic                    bus_transmit_output,
   input  wire logic [7:2]         port_in,
   output logic [7:2]              port_out,
   output logic [7:2]              port_oe,
   output logic                    eng_rx_bit,
   input  wire logic               eng_tx_bit,
   input  wire logic               eng_rx_valid,
   input  wire cmbm_pkg::cmbm_rx_t eng_rx,
   input  wire logic               eng_arb,
   input  wire logic               eng_tx_done,
   input  wire logic               eng_tx_fail,
   output logic                    tx_pending,
   output cmbm_pkg::cmbm_frame_t   tx_frame,
   output logic                    ack_enable,
   output logic                    rx_irq,
   output logic                    err_irq,
   output logic                    tx_irq
);
   logic [7:0]                  ctrl;
   logic [7:0]                  mask;
   logic [7:0]                  ddr;
   logic [7:2]                  port_dat;
   logic                        receive_full_flag;
   logic                        ovr;
   logic                        bg_pend;
   cmbm_pkg::cmbm_frame_t       fg;
   cmbm_pkg::cmbm_frame_t       bg;
   logic [2:0]                  transmit_buffer_empty_flag;
   logic [2:0]                  abort_acknowledge_bit;
   logic [2:0]                  abrq;
   logic [2:0][13:0][7:0]       txmem;
   logic                        busy;
   logic [1:0]                  sel;
   logic [2:0]                  queued;
   logic [1:0]                  best;
   logic                        found;

   wire       wr  = psel & penable & pready & pwrite;
   wire [3:0] idx = paddr[5:2];
   wire [1:0] tn  = paddr[7:6];

   function automatic logic tx_slot(input logic [11:0] a);
      return a[11:8] == cmbm_pkg::TX_WIN && a[7:6] != 2'h3
         && a[5:2] <= cmbm_pkg::LOCAL_PRIORITY_FIELD_IDX;
   endfunction : tx_slot

   function automatic logic rx_slot(input logic [11:0] a);
      return a[11:6] == cmbm_pkg::RX_WIN && a[5:2] < 4'hD;
   endfunction : rx_slot

   // Own frames outside loop-back never reach the foreground
   wire own_skip = eng_rx.own & ~ctrl[cmbm_pkg::CTRL_LOOP];
   wire acc_rx   = eng_rx_valid & eng_rx.hit & ~own_skip;
   wire clr_rxf  = wr && paddr == cmbm_pkg::A_RXFLAG && pwdata[cmbm_pkg::RXF_BIT];
   wire clr_ovr  = wr && paddr == cmbm_pkg::A_RXFLAG && pwdata[cmbm_pkg::OVR_BIT];
   wire full     = receive_full_flag & bg_pend;

   // APB: one wait-free access, answer registered during setup
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & ~penable & ~pready;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         if (rx_slot(paddr)) begin
            prdata[7:0] <= fg[idx];
         end else if (tx_slot(paddr)) begin
            prdata[7:0] <= txmem[tn][idx];
         end else begin
            unique case (paddr)
               cmbm_pkg::A_CTRL:   prdata[7:0] <= ctrl;
               cmbm_pkg::A_RXFLAG: prdata[1:0] <= {ovr, receive_full_flag};
               cmbm_pkg::A_TXFLAG: prdata[6:0] <= {abort_acknowledge_bit, 1'b0, transmit_buffer_empty_flag};
               cmbm_pkg::A_TXCTRL: prdata[2:0] <= abrq;
               cmbm_pkg::A_PORT: begin
                  prdata[7:0] <= {(ddr[7:2] & port_dat) | (~ddr[7:2] & port_in),
                                  bus_transmit_output, bus_receive_input};
               end
               cmbm_pkg::A_DDR:    prdata[7:0] <= ddr;
               cmbm_pkg::A_MASK:   prdata[7:0] <= mask;
               default:            pslverr <= 1'b1;
            endcase
         end
      end
   end

   // Control, mask and port registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl     <= cmbm_pkg::CTRL_RST;
         mask     <= cmbm_pkg::MASK_RST;
         ddr      <= cmbm_pkg::DDR_RST;
         port_dat <= 6'h00;
      end else if (wr) begin
         if (paddr == cmbm_pkg::A_CTRL) ctrl <= pwdata[7:0];
         if (paddr == cmbm_pkg::A_MASK) mask <= pwdata[7:0];
         if (paddr == cmbm_pkg::A_DDR) ddr <= pwdata[7:0];
         if (paddr == cmbm_pkg::A_PORT) port_dat <= pwdata[7:2];
      end
   end

   // Pins: bus_transmit_output recessive when disabled
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bus_transmit_output <= 1'b1;
         eng_rx_bit          <= 1'b1;
         port_out            <= 6'h00;
         port_oe             <= 6'h00;
      end else begin
         bus_transmit_output <= ctrl[cmbm_pkg::CTRL_EN] ? eng_tx_bit : 1'b1;
         eng_rx_bit          <= bus_receive_input;
         port_out            <= port_dat;
         port_oe             <= ddr[7:2];
      end
   end

   // Background entry takes every frame unless both entries are full
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bg <= '0;
      end else if (eng_rx_valid && !full) begin
         bg <= eng_rx.frame;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fg      <= '0;
         receive_full_flag     <= 1'b0;
         bg_pend <= 1'b0;
      end else if (!receive_full_flag && bg_pend) begin
         fg      <= bg;
         receive_full_flag     <= 1'b1;
         bg_pend <= acc_rx;
      end else if (!receive_full_flag && acc_rx) begin
         fg  <= eng_rx.frame;
         receive_full_flag <= 1'b1;
      end else begin
         if (receive_full_flag && acc_rx) bg_pend <= 1'b1;
         if (clr_rxf) receive_full_flag <= 1'b0;
      end
   end

   // Overrun: set wins over the write-one clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ovr <= 1'b0;
      end else if (acc_rx && full) begin
         ovr <= 1'b1;
      end else if (clr_ovr) begin
         ovr <= 1'b0;
      end
   end

   // Interrupt lines follow the sticky flags one edge later
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_irq  <= 1'b0;
         err_irq <= 1'b0;
         tx_irq  <= 1'b0;
      end else begin
         rx_irq  <= receive_full_flag & mask[cmbm_pkg::MASK_RXF];
         err_irq <= ovr & mask[cmbm_pkg::MASK_OVR];
         tx_irq  <= |(transmit_buffer_empty_flag & mask[cmbm_pkg::MASK_TXE+:3]);
      end
   end

   // Three transmit buffers with their flags
   genvar gi;
   generate
      for (gi = 0; gi < cmbm_pkg::TX_N; gi++) begin : g_tx
         wire sending = busy && sel == 2'(gi);
         wire sw_wr   = wr && tx_slot(paddr) && tn == 2'(gi);
         wire sw_q    = wr && paddr == cmbm_pkg::A_TXFLAG && pwdata[gi];
         wire grant   = abrq[gi] && !transmit_buffer_empty_flag[gi] && !sending;
         wire sent    = eng_tx_done && sending;
         assign queued[gi] = ~transmit_buffer_empty_flag[gi];

         // Contents frozen while queued, so a retry resends the same frame
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               txmem[gi] <= '0;
            end else if (sw_wr && transmit_buffer_empty_flag[gi]) begin
               txmem[gi][idx] <= pwdata[7:0];
            end
         end

         always_ff @(posedge ref_clk) begin
            if (rst) begin
               transmit_buffer_empty_flag[gi]   <= cmbm_pkg::TXE_RST[gi];
               abort_acknowledge_bit[gi] <= 1'b0;
               abrq[gi]  <= 1'b0;
            end else if (sent) begin
               transmit_buffer_empty_flag[gi]   <= 1'b1;
               abort_acknowledge_bit[gi] <= 1'b0;
               abrq[gi]  <= 1'b0;
            end else if (grant) begin
               transmit_buffer_empty_flag[gi]   <= 1'b1;
               abort_acknowledge_bit[gi] <= 1'b1;
               abrq[gi]  <= 1'b0;
            end else begin
               if (sw_q) begin
                  transmit_buffer_empty_flag[gi]   <= 1'b0;
                  abort_acknowledge_bit[gi] <= 1'b0;
               end
               if (wr && paddr == cmbm_pkg::A_TXCTRL && pwdata[gi] && !transmit_buffer_empty_flag[gi]) begin
                  abrq[gi] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // Lowest priority value wins; ties go to the lower buffer
   always_comb begin
      found = 1'b0;
      best  = 2'h0;
      for (int i = 0; i < cmbm_pkg::TX_N; i++) begin
         if (queued[i] && (!found || txmem[i][13] < txmem[best][13])) begin
            found = 1'b1;
            best  = i[1:0];
         end
      end
   end

   // Scheduler reruns the pick at every arbitration
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busy     <= 1'b0;
         sel      <= 2'h0;
         tx_frame <= '0;
      end else if (busy) begin
         if (eng_tx_done || eng_tx_fail) busy <= 1'b0;
      end else if (eng_arb && found) begin
         busy     <= 1'b1;
         sel      <= best;
         tx_frame <= txmem[best][12:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_pending <= 1'b0;
         ack_enable <= 1'b1;
      end else begin
         tx_pending <= |queued;
         ack_enable <= ctrl[cmbm_pkg::CTRL_LOOP] | ~busy;
      end
   end

   property p_recessive;
      @(posedge ref_clk) disable iff (rst)
      !ctrl[cmbm_pkg::CTRL_EN] |=> bus_transmit_output;
   endproperty
   a_recessive: assert property (p_recessive) else $error("tx not recessive");

   property p_copy;
      @(posedge ref_clk) disable iff (rst)
      acc_rx && !receive_full_flag && !bg_pend |=> receive_full_flag && fg == $past(eng_rx.frame);
   endproperty
   a_copy: assert property (p_copy) else $error("frame not copied");

   property p_overrun;
      @(posedge ref_clk) disable iff (rst)
      acc_rx && full |=> ovr && $stable(fg) && $stable(bg);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed");

   property p_own;
      @(posedge ref_clk) disable iff (rst)
      eng_rx_valid && own_skip && !receive_full_flag && !bg_pend |=> !receive_full_flag && $stable(fg);
   endproperty
   a_own: assert property (p_own) else $error("own frame shown");

   property p_sent;
      @(posedge ref_clk) disable iff (rst)
      eng_tx_done && busy |=> transmit_buffer_empty_flag[$past(sel)] && !abort_acknowledge_bit[$past(sel)] && !busy;
   endproperty
   a_sent: assert property (p_sent) else $error("empty flag not set");

   property p_pick;
      @(posedge ref_clk) disable iff (rst)
      eng_arb && !busy && found |=> busy && sel == $past(best)
         && tx_frame == $past(txmem[best][12:0]);
   endproperty
   a_pick: assert property (p_pick) else $error("wrong buffer picked");

   property p_noabort;
      @(posedge ref_clk) disable iff (rst)
      busy && !eng_tx_done && !eng_tx_fail |=> !$rose(abort_acknowledge_bit[sel]);
   endproperty
   a_noabort: assert property (p_noabort) else $error("sending frame aborted");

   property p_frozen;
      @(posedge ref_clk) disable iff (rst)
      wr && tx_slot(paddr) && !transmit_buffer_empty_flag[tn] |=> $stable(txmem);
   endproperty
   a_frozen: assert property (p_frozen) else $error("queued buffer changed");
endmodule : cmbm_core
`default_nettype wire

// ===== verif/cmbm_engine_model.sv
// Stand-in for the external CAN bit engine on the transmit side.
// Assumes tx_pending from the buffer manager; one frame in flight.
`timescale 1ns/10ps
`default_nettype none
module cmbm_engine_model (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic tx_pending,
   input  wire logic slow,
   output logic      eng_arb,
   output logic      eng_tx_done,
   output logic      eng_tx_fail,
   output logic      eng_tx_bit
);
   logic [7:0] cnt;
   logic       busy;
   logic       tried;
   // Idle gap after a frame stands for the interframe space, so a stale pending is not seen
   always_ff @(posedge ref_clk) begin
      eng_arb <= 1'b0;
      eng_tx_done <= 1'b0;
      eng_tx_fail <= 1'b0;
      if (rst) begin
         busy <= 1'b0;
         tried <= 1'b0;
         cnt <= 8'h08;
         eng_tx_bit <= 1'b1;
      end else if (busy) begin
         cnt <= cnt - 8'h01;
         if (cnt == 8'h01) begin
            busy <= 1'b0;
            cnt <= 8'h08;
            // First frame after reset is lost once, so the pick must be redone
            eng_tx_fail <= ~tried;
            eng_tx_done <= tried;
            tried <= 1'b1;
            eng_tx_bit <= 1'b1;
         end
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
      end else if (tx_pending) begin
         eng_arb <= 1'b1;
         busy <= 1'b1;
         cnt <= slow ? 8'hC8 : 8'h14;
         eng_tx_bit <= 1'b0;
      end
   end
endmodule : cmbm_engine_model
`default_nettype wire

// ===== verif/can_message_buffer_manager_bench.sv
// Self-checking bench for the CAN message buffer manager core.
// Assumes the engine model on the transmit side; APB and receive pulses driven here.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
   $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module can_message_buffer_manager_bench;
   logic                  ref_clk, rst, psel, penable, pwrite, pready, pslverr, err, slow;
   logic                  bus_receive_input, bus_transmit_output, eng_rx_bit, eng_tx_bit;
   logic                  eng_rx_valid, eng_arb, eng_tx_done, eng_tx_fail, tx_pending;
   logic                  ack_enable, rx_irq, err_irq, tx_irq;
   logic [11:0]           paddr;
   logic [31:0]           pwdata, prdata, q;
   logic [7:2]            port_in, port_out, port_oe;
   cmbm_pkg::cmbm_rx_t    eng_rx;
   cmbm_pkg::cmbm_frame_t tx_frame;
   logic [7:0]            sent[$];
   int                    bad_count, total_checks, cycles;
   cmbm_core uut (.ref_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .bus_receive_input, .bus_transmit_output, .port_in, .port_out, .port_oe,
      .eng_rx_bit, .eng_tx_bit, .eng_rx_valid, .eng_rx, .eng_arb, .eng_tx_done, .eng_tx_fail,
      .tx_pending, .tx_frame, .ack_enable, .rx_irq, .err_irq, .tx_irq);
   cmbm_engine_model partner (.ref_clk, .rst, .tx_pending, .slow, .eng_arb, .eng_tx_done,
      .eng_tx_fail, .eng_tx_bit);
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // Run is a few hundred cycles; the ceiling leaves wide margin
   always @(posedge ref_clk) begin
      cycles++;
      if (eng_tx_done === 1'b1) sent.push_back(tx_frame[0]);
      if (cycles == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_txe;
      do begin
         apb(1'b0, cmbm_pkg::A_TXFLAG, 32'h0);
      end while (q[2:0] !== 3'h7);
   endtask : wait_txe
   task automatic rx_frame(input logic own, input logic [7:0] b);
      @(posedge ref_clk);
      eng_rx_valid <= 1'b1;
      eng_rx.hit <= 1'b1;
      eng_rx.own <= own;
      for (int i = 0; i < cmbm_pkg::FRAME_BYTES; i++) eng_rx.frame[i] <= b + 8'(i);
      @(posedge ref_clk);
      eng_rx_valid <= 1'b0;
   endtask : rx_frame
   task automatic t_reset;
      `CHK("tx pin", 1'b1, bus_transmit_output)
      `CHK("pending", 1'b0, tx_pending)
      `CHK("ack idle", 1'b1, ack_enable)
      apb(1'b0, cmbm_pkg::A_TXFLAG, 32'h0);
      `CHK("txflag", 32'h7, q)
      apb(1'b0, 12'h020, 32'h0);
      `CHK("unmapped", 1'b1, err)
   endtask : t_reset
   task automatic t_port;
      bus_receive_input <= 1'b0;
      apb(1'b0, cmbm_pkg::A_PORT, 32'h0);
      `CHK("rx pin", 1'b0, q[0])
      `CHK("rx bit", 1'b0, eng_rx_bit)
      apb(1'b1, cmbm_pkg::A_DDR, 32'hFC);
      apb(1'b1, cmbm_pkg::A_PORT, 32'hA8);
      repeat (2) @(posedge ref_clk);
      `CHK("port oe", 6'h3F, port_oe)
      `CHK("port out", 6'h2A, port_out)
      bus_receive_input <= 1'b1;
   endtask : t_port
   task automatic t_rx;
      apb(1'b1, cmbm_pkg::A_MASK, 32'h1F);
      apb(1'b1, cmbm_pkg::A_CTRL, 32'h2);
      rx_frame(1'b1, 8'h30);
      apb(1'b0, cmbm_pkg::A_RXFLAG, 32'h0);
      `CHK("own rxf", 32'h0, q)
      rx_frame(1'b0, 8'h40);
      apb(1'b0, cmbm_pkg::A_RXFLAG, 32'h0);
      `CHK("rxf", 32'h1, q)
      `CHK("rx irq", 1'b1, rx_irq)
      apb(1'b0, 12'h040, 32'h0);
      `CHK("byte 0", 32'h40, q)
      apb(1'b0, 12'h070, 32'h0);
      `CHK("byte 12", 32'h4C, q)
      rx_frame(1'b0, 8'h50);
      apb(1'b0, 12'h040, 32'h0);
      `CHK("fg kept", 32'h40, q)
      rx_frame(1'b0, 8'h60);
      apb(1'b0, cmbm_pkg::A_RXFLAG, 32'h0);
      `CHK("overrun", 32'h3, q)
      `CHK("err irq", 1'b1, err_irq)
      apb(1'b0, 12'h040, 32'h0);
      `CHK("fg full", 32'h40, q)
      apb(1'b1, cmbm_pkg::A_RXFLAG, 32'h3);
      apb(1'b1, cmbm_pkg::A_RXFLAG, 32'h3);
      apb(1'b1, cmbm_pkg::A_CTRL, 32'h3);
      rx_frame(1'b1, 8'h70);
      apb(1'b0, 12'h040, 32'h0);
      `CHK("loop byte", 32'h70, q)
      apb(1'b1, cmbm_pkg::A_RXFLAG, 32'h3);
      apb(1'b1, cmbm_pkg::A_CTRL, 32'h2);
   endtask : t_rx
   task automatic t_local_priority_field;
      logic [7:0] pr [3];
      pr = '{8'h1E, 8'h0A, 8'h14};
      for (int n = 0; n < 3; n++) begin
         apb(1'b1, 12'h100 + 12'(n * 64), 32'hA0 + 32'(n));
         apb(1'b1, 12'h134 + 12'(n * 64), {24'h0, pr[n]});
      end
      sent.delete();
      apb(1'b1, cmbm_pkg::A_TXFLAG, 32'h7);
      apb(1'b1, 12'h100, 32'h55);
      wait_txe;
      `CHK("sent count", 3, sent.size())
      `CHK("first", 8'hA1, sent[0])
      `CHK("second", 8'hA2, sent[1])
      `CHK("third", 8'hA0, sent[2])
      `CHK("tx irq", 1'b1, tx_irq)
   endtask : t_local_priority_field
   task automatic t_abort;
      slow <= 1'b1;
      apb(1'b1, 12'h134, 32'h05);
      apb(1'b1, 12'h1B4, 32'h09);
      apb(1'b1, cmbm_pkg::A_TXFLAG, 32'h5);
      // Let the pick land first so only the idle buffer can be withdrawn
      repeat (4) @(posedge ref_clk);
      apb(1'b1, cmbm_pkg::A_TXCTRL, 32'h5);
      apb(1'b0, cmbm_pkg::A_TXFLAG, 32'h0);
      `CHK("abort grant", 32'h46, q)
      `CHK("dominant", 1'b0, bus_transmit_output)
      `CHK("no self ack", 1'b0, ack_enable)
      wait_txe;
      `CHK("abort ack", 32'h47, q)
      slow <= 1'b0;
   endtask : t_abort
   task tally_and_finish;
      if (bad_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      bus_receive_input = 1'b1;
      port_in = 6'h15;
      eng_rx_valid = 1'b0;
      eng_rx = '0;
      slow = 1'b0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset;
      t_port;
      t_rx;
      t_local_priority_field;
      t_abort;
      tally_and_finish;
   end
endmodule : can_message_buffer_manager_bench
`default_nettype wire
